// ===== rtl/mcuic_params.svh
// constants for the interrupt controller: field positions, reset values, timing
`ifndef MCUIC_PARAMS_SVH
`define MCUIC_PARAMS_SVH
`define MCUIC_CTL_GLOBAL_EN 7
`define MCUIC_CTL_PERIPH_EN 6
`define MCUIC_CTL_TIMER_EN 5
`define MCUIC_CTL_PIN_EN 4
`define MCUIC_CTL_CHANGE_EN 3
`define MCUIC_CTL_TIMER_FLAG 2
`define MCUIC_CTL_PIN_FLAG 1
`define MCUIC_CTL_CHANGE_FLAG 0
`define MCUIC_PF_CONV_FLAG 6
`define MCUIC_CTL_RESET 8'h00
`define MCUIC_PER_RESET 8'h00
`define MCUIC_VECTOR 13'h0004
`define MCUIC_SYNC_CYCLES 2
`define MCUIC_RETURN_CYCLES 2
`endif

// ===== rtl/mcuic_pkg.sv
// types shared by the interrupt controller files
package mcuic_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic ctl_we;
        logic pfa_we;
        logic pfb_we;
        logic pea_we;
        logic peb_we;
    } mcuic_wr_t;
    typedef struct packed {
        logic ext_pin;
        logic timer_zero_ovf;
        logic [3:0] port_change_pins;
        logic adc_done;
        logic [7:0] periph_b_events;
    } mcuic_evt_t;
    typedef enum logic [1:0] {
        MCUIC_RUN = 2'b00,
        MCUIC_VEC = 2'b01,
        MCUIC_RET = 2'b10
    } mcuic_state_t;
endpackage

// ===== rtl/mcuic_edge.sv
// one-bit edge detector giving a single-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module mcuic_edge (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic sig,
    output logic pulse
);
    logic last_reg;
    logic last_next;
    // track previous level
    always_comb
    begin
        last_next = sig;
    end
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            last_reg <= 1'b0;
        else
            last_reg <= last_next;
    end
    assign pulse = sig ^ last_reg; // either edge
endmodule
`default_nettype wire

// ===== rtl/mcuic_top.sv
// interrupt controller of a small 8-bit core: flags, masks, global enable, vectoring
// Notes on behaviour
// - sources: pin, timer, port change, converter, eight flag register b events
// - flags set regardless of mask or enable
// - global enable bit 7 gates all requests
// - enabled unmasked flagged source vectors at once
// - reset clears the global enable
// - return instruction sets global enable again
// - core flags in control, peripheral in others
// - accept clears enable, pushes, jumps 0004h
// - external events reach vector in 3-4 cycles
// - acknowledge during enable clear still vectors
// - return loads stack top, takes two cycles
`timescale 1ns/10ps
`default_nettype none
`include "mcuic_params.svh"
module mcuic_top (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire mcuic_pkg::mcuic_evt_t events,
    input wire mcuic_pkg::mcuic_wr_t wr,
    input wire logic ext_edge_rising,
    input wire logic return_from_irq,
    input wire logic [12:0] stack_top,
    input wire logic [12:0] pc_now,
    output logic [7:0] irq_control_reg,
    output logic [7:0] periph_flag_reg_a,
    output logic [7:0] periph_flag_reg_b,
    output logic [7:0] periph_enable_reg_a,
    output logic [7:0] periph_enable_reg_b,
    output logic vector_take,
    output logic [12:0] pc_load,
    output logic pc_load_en,
    output logic stack_push,
    output logic [12:0] stack_push_data,
    output logic stack_pop,
    output logic in_service
);
    import mcuic_pkg::*;

    logic [1:0] ext_sync_reg;
    logic [1:0] ext_sync_next;
    logic [3:0] pc_sync1_reg;
    logic [3:0] pc_sync2_reg;
    logic [3:0] pc_sync1_next;
    logic [3:0] pc_sync2_next;
    logic [3:0] pc_change;
    logic ext_prev_reg;
    logic ext_prev_next;
    logic ext_event;
    logic rb_event;
    logic [7:0] ctl_reg;
    logic [7:0] ctl_next;
    logic [7:0] pfa_reg;
    logic [7:0] pfa_next;
    logic [7:0] pfb_reg;
    logic [7:0] pfb_next;
    logic [7:0] pea_reg;
    logic [7:0] pea_next;
    logic [7:0] peb_reg;
    logic [7:0] peb_next;
    logic irq_pending;
    mcuic_state_t state_reg;
    mcuic_state_t state_next;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic take_reg;
    logic take_next;
    logic [12:0] pcl_reg;
    logic [12:0] pcl_next;
    logic pcl_en_reg;
    logic pcl_en_next;
    logic push_reg;
    logic push_next;
    logic [12:0] push_data_reg;
    logic [12:0] push_data_next;
    logic pop_reg;
    logic pop_next;
    logic svc_reg;
    logic svc_next;

    // two-stage sampling of the external pin and change pins; adds the latency spread
    always_comb
    begin
        ext_sync_next = {ext_sync_reg[0], events.ext_pin};
        ext_prev_next = ext_sync_reg[1];
        pc_sync1_next = events.port_change_pins;
        pc_sync2_next = pc_sync1_reg;
    end
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ext_sync_reg <= 2'b00;
            ext_prev_reg <= 1'b0;
            pc_sync1_reg <= 4'h0;
            pc_sync2_reg <= 4'h0;
        end
        else
        begin
            ext_sync_reg <= ext_sync_next;
            ext_prev_reg <= ext_prev_next;
            pc_sync1_reg <= pc_sync1_next;
            pc_sync2_reg <= pc_sync2_next;
        end
    end

    // selected edge of external pin
    assign ext_event = ext_edge_rising ? (ext_sync_reg[1] & ~ext_prev_reg)
                                       : (~ext_sync_reg[1] & ext_prev_reg);

    // one change detector per upper port pin
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_chg
            mcuic_edge u_edge (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .sig(pc_sync2_reg[gi]),
                .pulse(pc_change[gi])
            );
        end
    endgenerate
    assign rb_event = |pc_change;

    // request when enabled and any flag meets its mask
    always_comb
    begin
        irq_pending = ctl_reg[`MCUIC_CTL_GLOBAL_EN] & (
            (ctl_reg[`MCUIC_CTL_TIMER_EN] & ctl_reg[`MCUIC_CTL_TIMER_FLAG]) |
            (ctl_reg[`MCUIC_CTL_PIN_EN] & ctl_reg[`MCUIC_CTL_PIN_FLAG]) |
            (ctl_reg[`MCUIC_CTL_CHANGE_EN] & ctl_reg[`MCUIC_CTL_CHANGE_FLAG]) |
            (ctl_reg[`MCUIC_CTL_PERIPH_EN] & ((|(pfa_reg & pea_reg)) | (|(pfb_reg & peb_reg)))));
    end

    // flag and enable registers: software write first, hardware set wins
    always_comb
    begin
        ctl_next = wr.ctl_we ? wr.data : ctl_reg; // software write path
        pfa_next = wr.pfa_we ? wr.data : pfa_reg;
        pfb_next = wr.pfb_we ? wr.data : pfb_reg;
        pea_next = wr.pea_we ? wr.data : pea_reg;
        peb_next = wr.peb_we ? wr.data : peb_reg;
        if (state_reg == MCUIC_RUN && irq_pending)
            ctl_next[`MCUIC_CTL_GLOBAL_EN] = 1'b0;
        // a return is ignored while a request wins, so it must not re-enable then
        if (state_reg == MCUIC_RUN && return_from_irq && !irq_pending)
            ctl_next[`MCUIC_CTL_GLOBAL_EN] = 1'b1;
        if (events.timer_zero_ovf)
            ctl_next[`MCUIC_CTL_TIMER_FLAG] = 1'b1;
        if (ext_event)
            ctl_next[`MCUIC_CTL_PIN_FLAG] = 1'b1;
        if (rb_event)
            ctl_next[`MCUIC_CTL_CHANGE_FLAG] = 1'b1;
        if (events.adc_done)
            pfa_next[`MCUIC_PF_CONV_FLAG] = 1'b1;
        pfb_next = pfb_next | events.periph_b_events;
    end
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctl_reg <= `MCUIC_CTL_RESET;
            pfa_reg <= `MCUIC_PER_RESET;
            pfb_reg <= `MCUIC_PER_RESET;
            pea_reg <= `MCUIC_PER_RESET;
            peb_reg <= `MCUIC_PER_RESET;
        end
        else
        begin
            ctl_reg <= ctl_next;
            pfa_reg <= pfa_next;
            pfb_reg <= pfb_next;
            pea_reg <= pea_next;
            peb_reg <= peb_next;
        end
    end

    // vectoring and return sequencer
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        take_next = 1'b0;
        pcl_next = pcl_reg;
        pcl_en_next = 1'b0;
        push_next = 1'b0;
        push_data_next = push_data_reg;
        pop_next = 1'b0;
        svc_next = svc_reg;
        unique case (state_reg)
            MCUIC_RUN:
            begin
                if (irq_pending)
                begin
                    state_next = MCUIC_VEC;
                    take_next = 1'b1;
                    push_next = 1'b1;
                    push_data_next = pc_now;
                    pcl_next = `MCUIC_VECTOR;
                    pcl_en_next = 1'b1;
                    svc_next = 1'b1;
                end
                else if (return_from_irq)
                begin
                    state_next = MCUIC_RET;
                    pop_next = 1'b1;
                    pcl_next = stack_top;
                    pcl_en_next = 1'b1;
                    cnt_next = 2'(`MCUIC_RETURN_CYCLES - 1);
                end
            end
            MCUIC_VEC:
            begin
                state_next = MCUIC_RUN;
            end
            MCUIC_RET:
            begin
                if (cnt_reg == 2'd1)
                begin
                    state_next = MCUIC_RUN;
                    svc_next = 1'b0;
                end
                cnt_next = cnt_reg - 2'd1;
            end
            default:
            begin
                state_next = MCUIC_RUN;
            end
        endcase
    end
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= MCUIC_RUN;
            cnt_reg <= 2'd0;
            take_reg <= 1'b0;
            pcl_reg <= 13'h0000;
            pcl_en_reg <= 1'b0;
            push_reg <= 1'b0;
            push_data_reg <= 13'h0000;
            pop_reg <= 1'b0;
            svc_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            take_reg <= take_next;
            pcl_reg <= pcl_next;
            pcl_en_reg <= pcl_en_next;
            push_reg <= push_next;
            push_data_reg <= push_data_next;
            pop_reg <= pop_next;
            svc_reg <= svc_next;
        end
    end

    // outputs straight from flip-flops
    assign irq_control_reg = ctl_reg;
    assign periph_flag_reg_a = pfa_reg;
    assign periph_flag_reg_b = pfb_reg;
    assign periph_enable_reg_a = pea_reg;
    assign periph_enable_reg_b = peb_reg;
    assign vector_take = take_reg;
    assign pc_load = pcl_reg;
    assign pc_load_en = pcl_en_reg;
    assign stack_push = push_reg;
    assign stack_push_data = push_data_reg;
    assign stack_pop = pop_reg;
    assign in_service = svc_reg;

    // checks
    flag_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        events.timer_zero_ovf |=> ctl_reg[`MCUIC_CTL_TIMER_FLAG])
        else $error("timer flag not set");
    adc_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        events.adc_done |=> pfa_reg[`MCUIC_PF_CONV_FLAG])
        else $error("converter flag not set");
    gie_block_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !ctl_reg[`MCUIC_CTL_GLOBAL_EN] |=> !take_reg)
        else $error("vector taken while disabled");
    vector_now_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_reg == MCUIC_RUN && irq_pending) |=> take_reg && pcl_en_reg)
        else $error("pending request not vectored");
    vector_addr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        take_reg |-> pcl_reg == `MCUIC_VECTOR && push_reg && !ctl_reg[`MCUIC_CTL_GLOBAL_EN])
        else $error("bad vector sequence");
    ret_gie_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_reg == MCUIC_RUN && !irq_pending && return_from_irq) |=> ctl_reg[`MCUIC_CTL_GLOBAL_EN])
        else $error("return did not re-enable");
    ret_len_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(pop_reg) |-> state_reg == MCUIC_RET ##1 state_reg == MCUIC_RUN)
        else $error("return not two cycles");
    ext_latency_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (ext_edge_rising && $rose(events.ext_pin)) |-> ##3 ctl_reg[`MCUIC_CTL_PIN_FLAG])
        else $error("pin flag late");
    reset_gie_a: assert property (@(posedge ref_clk)
        !rstn |-> !ctl_reg[`MCUIC_CTL_GLOBAL_EN])
        else $error("enable set in reset");
endmodule
`default_nettype wire

// ===== sim/mcuic_core_model.sv
// core-side model: the return stack that the interrupt logic pushes and pops
`timescale 1ns/10ps
`default_nettype none
module mcuic_core_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic stack_push,
    input wire logic [12:0] stack_push_data,
    input wire logic stack_pop,
    output logic [12:0] stack_top
);
    logic [12:0] stack_mem [0:7];
    logic [2:0] sp_reg;
    logic [2:0] top_idx;
    // push on vector acceptance, pop on return
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            sp_reg <= 3'h0;
        else if (stack_push)
        begin
            stack_mem[sp_reg] <= stack_push_data;
            sp_reg <= sp_reg + 3'h1;
        end
        else if (stack_pop)
            sp_reg <= sp_reg - 3'h1;
    end
    // an empty stack shows a pattern no test uses as a return address
    assign top_idx = sp_reg - 3'h1;
    assign stack_top = (sp_reg == 3'h0) ? 13'h1555 : stack_mem[top_idx];
endmodule
`default_nettype wire

// ===== sim/mcuic_top_tb.sv
// self-checking bench for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module mcuic_top_tb;
    import mcuic_pkg::*;
    logic ref_clk, rstn, edge_rise, ret, vec, ld_en, push, pop, in_srv;
    logic [7:0] ctl, pfa, pfb, pea, peb;
    logic [12:0] base, top, pc_ld, push_d;
    mcuic_evt_t evt;
    mcuic_wr_t wr;
    int error_cnt = 0;
    int check_count = 0;
    int n;
    logic [7:0] en_t [0:2] = '{8'h90, 8'h88, 8'hC0};
    logic [14:0] ev_t [0:2] = '{15'h4000, 15'h0a00, 15'h0100};
    logic [7:0] fl_t [0:2] = '{8'h12, 8'h09, 8'h40};
    mcuic_top mcuic_top_i (.ref_clk(ref_clk), .rstn(rstn), .events(evt), .wr(wr), .ext_edge_rising(edge_rise),
        .return_from_irq(ret), .stack_top(top), .pc_now(base), .irq_control_reg(ctl), .periph_flag_reg_a(pfa),
        .periph_flag_reg_b(pfb), .periph_enable_reg_a(pea), .periph_enable_reg_b(peb), .vector_take(vec),
        .pc_load(pc_ld), .pc_load_en(ld_en), .stack_push(push), .stack_push_data(push_d), .stack_pop(pop),
        .in_service(in_srv));
    mcuic_core_model mcuic_core_model_i (.ref_clk(ref_clk), .rstn(rstn), .stack_push(push),
        .stack_push_data(push_d), .stack_pop(pop), .stack_top(top));
    // clock at 40 MHz
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish();
        if (error_cnt == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    // one-cycle register write; we order is ctl, pfa, pfb, pea, peb
    task automatic wreg(input logic [7:0] d, input logic [4:0] we);
        tick(1);
        wr = {d, we};
        tick(1);
        wr = '0;
    endtask
    task automatic pulse(input logic [14:0] m);
        tick(1);
        evt = evt | m;
        tick(1);
        evt = evt & ~m;
    endtask
    // bounded wait for the vector pulse
    task automatic wait_vec(output int cnt);
        cnt = 0;
        while (vec !== 1'b1 && cnt < 20)
        begin
            tick(1);
            cnt++;
        end
        if (cnt == 20)
        begin
            error_cnt++;
            $display("[FAIL] %0t no vector", $time);
            tally_and_finish();
        end
    endtask
    // checks acceptance, clears flags as the service routine would, returns
    task automatic serve(input logic [12:0] pcv, input logic [7:0] ctl_exp);
        chk(16'(pc_ld), 16'h0004);
        chk(16'({ld_en, push}), 16'h0003);
        chk(16'(push_d), 16'(pcv));
        tick(1);
        chk(16'({in_srv, ctl}), 16'(ctl_exp) | 16'h0100);
        wreg(ctl_exp & 8'h78, 5'b10000);
        wreg(8'h00, 5'b01100);
        tick(1);
        ret = 1'b1;
        tick(1);
        ret = 1'b0;
        chk(16'({pop, ctl[7]}), 16'h0003);
        chk(16'(pc_ld), 16'(pcv));
        tick(1);
        chk(16'(in_srv), 16'h0000);
    endtask
    // main sequence
    initial
    begin
        rstn = 1'b0;
        evt = '0;
        wr = '0;
        ret = 1'b0;
        edge_rise = 1'b1;
        base = 13'h0123;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rstn = 1'b1;
        chk(16'({in_srv, vec, ctl}), 16'h0000);
        // flags rise while masked and globally disabled
        pulse(15'h2108);
        tick(2);
        chk(16'(ctl), 16'h0004);
        chk(16'({pfa, pfb}), 16'h4008);
        chk(16'(vec), 16'h0000);
        wreg(8'h00, 5'b01100);
        // pending timer flag vectors once enabled
        wreg(8'hA4, 5'b10000);
        wait_vec(n);
        serve(base, 8'h24);
        // pin, port change and converter sources in turn
        for (int i = 0; i < 3; i++)
        begin
            base = 13'(13'h0200 + i);
            wreg(en_t[i], 5'b10000);
            wreg(8'h40, 5'b00010);
            tick(1);
            evt = evt ^ ev_t[i];
            tick(1);
            if (i == 2)
                evt = evt ^ ev_t[i];
            wait_vec(n);
            if (i < 2)
                chk(16'(n >= 2 && n <= 3), 16'h0001);
            chk(16'(pfa), (i == 2) ? 16'h0040 : 16'h0000);
            serve(base, fl_t[i]);
        end
        // global enable cleared in the very cycle the request is taken
        base = 13'h0777;
        tick(1);
        wr = {8'hA4, 5'b10000};
        tick(1);
        wr = {8'h24, 5'b10000};
        tick(1);
        wr = '0;
        wait_vec(n);
        serve(base, 8'h24);
        // falling pin edge selected: same path, same latency
        base = 13'h0345;
        edge_rise = 1'b0;
        wreg(8'h90, 5'b10000);
        tick(1);
        evt = evt ^ 15'h4000;
        tick(1);
        wait_vec(n);
        chk(16'(n >= 2 && n <= 3), 16'h0001);
        serve(base, 8'h12);
        // flag register b reaches the core through its own enable
        base = 13'h0456;
        wreg(8'h08, 5'b00001);
        chk(16'({pea, peb}), 16'h4008);
        wreg(8'hC0, 5'b10000);
        pulse(15'h0008);
        chk(16'(pfb), 16'h0008);
        wait_vec(n);
        serve(base, 8'h40);
        // clear the global enable and read it back until it stays clear
        n = 0;
        do
        begin
            wreg(ctl & 8'h7F, 5'b10000);
            n++;
        end
        while (ctl[7] !== 1'b0 && n < 4);
        chk(16'(ctl[7]), 16'h0000);
        tally_and_finish();
    end
    // hang guard
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        $display("[FAIL] %0t run limit reached", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire
